// *** vsource_excitation_pkg.sv ***
/*
  Constants, field layouts and decode helpers shared by the reference and
  excitation register slice and its AXI4-Lite port.
  Assumes byte addresses of 8 bits and 32-bit data words.
*/
package vsource_excitation_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Printed register indices; each register occupies one aligned word.
  localparam logic [ADDR_W-1:0] VSOURCE_CTRL_IDX = 8'h05;
  localparam logic [ADDR_W-1:0] EXC_LEVEL_IDX = 8'h06;
  localparam logic [ADDR_W-1:0] EXC_ROUTE_IDX = 8'h07;
  localparam logic [ADDR_W-1:0] VSOURCE_CTRL_ADDR = ADDR_W'(VSOURCE_CTRL_IDX * 4);
  localparam logic [ADDR_W-1:0] EXC_LEVEL_ADDR = ADDR_W'(EXC_LEVEL_IDX * 4);
  localparam logic [ADDR_W-1:0] EXC_ROUTE_ADDR = ADDR_W'(EXC_ROUTE_IDX * 4);
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h40;

  localparam logic [REG_W-1:0] VSOURCE_CTRL_RESET = 8'h10;
  localparam logic [REG_W-1:0] EXC_LEVEL_RESET = 8'h00;
  localparam logic [REG_W-1:0] EXC_ROUTE_RESET = 8'hFF;

  // Field positions.
  localparam int MONITOR_EN_BIT = 6;
  localparam int POS_BYPASS_BIT = 5;
  localparam int NEG_BYPASS_BIT = 4;
  localparam int INPUT_SEL_LSB = 2;
  localparam int INT_CONFIG_LSB = 0;
  localparam int MAGNITUDE_LSB = 0;
  localparam int ROUTE_TWO_LSB = 4;
  localparam int ROUTE_ONE_LSB = 0;

  typedef enum logic [1:0] {SEL_PAIR0, SEL_PAIR1, SEL_INTERNAL, SEL_RESERVED} input_sel_t;
  typedef enum logic [1:0] {INT_OFF, INT_ON_SLEEPS, INT_ALWAYS_ON, INT_RESERVED} int_config_t;

  localparam logic [3:0] ROUTE_LAST_AIN = 4'hB;
  localparam logic [3:0] ROUTE_COMMON = 4'hC;
  localparam logic [3:0] ROUTE_PAIR1_POS = 4'h6;
  localparam logic [3:0] ROUTE_PAIR1_NEG = 4'h7;
  localparam logic [3:0] ROUTE_LAST_SMALL_AIN = 4'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Magnitude code to microamperes; codes beyond the table mean off.
  function automatic logic [11:0] magnitude_to_ua(input logic [3:0] code);
    logic [11:0] ua;
    ua = 12'h000;
    unique case (code)
      4'h1: ua = 12'd10;
      4'h2: ua = 12'd50;
      4'h3: ua = 12'd100;
      4'h4: ua = 12'd250;
      4'h5: ua = 12'd500;
      4'h6: ua = 12'd750;
      4'h7: ua = 12'd1000;
      4'h8: ua = 12'd1500;
      4'h9: ua = 12'd2000;
      default: ua = 12'h000;
    endcase
    return ua;
  endfunction : magnitude_to_ua

endpackage : vsource_excitation_pkg

// *** axil_reg_port.sv ***
/*
  AXI4-Lite slave front end: takes write address and data in either order,
  hands one write or read strobe to the register file and returns its answer.
  Assumes the register file decodes hits combinationally in the same cycle.
*/
`timescale 1ns/1ps
module axil_reg_port
  import vsource_excitation_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vsource_excitation_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [vsource_excitation_pkg::DATA_W-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [vsource_excitation_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [vsource_excitation_pkg::DATA_W-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [vsource_excitation_pkg::ADDR_W-1:0] wr_addr,
  output logic [vsource_excitation_pkg::DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic rd_en,
  output logic [vsource_excitation_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [vsource_excitation_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_hit
);
  logic aw_held_q, w_held_q, aw_take, w_take, aw_have, w_have;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;

  // Holding off both channels while a response waits keeps one write in flight.
  assign s_axil_awready = !aw_held_q && !s_axil_bvalid;
  assign s_axil_wready = !w_held_q && !s_axil_bvalid;
  assign aw_take = s_axil_awvalid && s_axil_awready;
  assign w_take = s_axil_wvalid && s_axil_wready;
  assign aw_have = aw_held_q || aw_take;
  assign w_have = w_held_q || w_take;
  assign wr_en = aw_have && w_have;
  assign wr_addr = aw_held_q ? awaddr_q : s_axil_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axil_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axil_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_held_q <= aw_have && !wr_en;
      w_held_q <= w_have && !wr_en;
      if (aw_take) begin
        awaddr_q <= s_axil_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axil_wdata;
        wstrb_q <= s_axil_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  assign s_axil_arready = !s_axil_rvalid;
  assign rd_en = s_axil_arvalid && s_axil_arready;
  assign rd_addr = s_axil_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= '0;
      s_axil_rresp <= RESP_OKAY;
    end else if (rd_en) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_hit ? rd_data : '0;
      s_axil_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

endmodule : axil_reg_port

// *** excitation_route_decoder.sv ***
/*
  Turns one current source's routing code into registered switch enables.
  Assumes the code comes from a register on the same clock.
*/
`timescale 1ns/1ps
module excitation_route_decoder #(
  parameter bit SIX_INPUT_VARIANT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] route_code,
  output logic [11:0] ain_switch,
  output logic common_switch,
  output logic pair1_pos_switch,
  output logic pair1_neg_switch,
  output logic connected
);
  import vsource_excitation_pkg::*;

  logic [11:0] ain_d;
  logic common_d, pos_d, neg_d;

  always_comb begin
    ain_d = 12'h000;
    common_d = 1'b0;
    pos_d = 1'b0;
    neg_d = 1'b0;
    if (SIX_INPUT_VARIANT && route_code == ROUTE_PAIR1_POS) begin
      pos_d = 1'b1; // [RULE12]
    end else if (SIX_INPUT_VARIANT && route_code == ROUTE_PAIR1_NEG) begin
      neg_d = 1'b1; // [RULE12]
    end else if (SIX_INPUT_VARIANT && route_code > ROUTE_LAST_SMALL_AIN && route_code <= ROUTE_LAST_AIN) begin
      // Inputs beyond the small package have no pin; the source stays open.
      ain_d = 12'h000; // [RULE12]
    end else if (route_code <= ROUTE_LAST_AIN) begin
      ain_d[route_code] = 1'b1; // [RULE10] [RULE11]
    end else if (route_code == ROUTE_COMMON) begin
      common_d = 1'b1; // [RULE10] [RULE11]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ain_switch <= 12'h000;
      common_switch <= 1'b0;
      pair1_pos_switch <= 1'b0;
      pair1_neg_switch <= 1'b0;
      connected <= 1'b0;
    end else begin
      ain_switch <= ain_d;
      common_switch <= common_d;
      pair1_pos_switch <= pos_d;
      pair1_neg_switch <= neg_d;
      connected <= (|ain_d) || common_d || pos_d || neg_d;
    end
  end

endmodule : excitation_route_decoder

// *** vsource_excitation_regs.sv ***
/*
  Reference control, excitation magnitude and excitation routing registers of
  a delta-sigma converter, reached over AXI4-Lite, with the decoded analog
  enables and switch controls they drive.
  Assumes one clock, a synchronous active-low reset and a power-down level
  from the converter's own sequencer on the same clock.

  // Contract
  // RULE1 - Bit 6 of reference control enables the external reference monitor; reset leaves it off.
  // RULE2 - Bit 5 of reference control bypasses the positive reference buffer when set; reset leaves it active.
  // RULE3 - Bit 4 of reference control resets to one, bypassing the negative buffer; writing zero enables it.
  // RULE4 - Bits 3:2 select reference pair zero, pair one or the internal reference, with code 11 reserved.
  // RULE5 - Bits 1:0 set the internal reference off, on but sleeping in power-down, or always on; 11 reserved.
  // RULE6 - Software should bypass both reference buffers whenever the internal reference is selected.
  // RULE7 - Software must turn the internal reference on before programming a nonzero excitation magnitude.
  // RULE8 - One four-bit magnitude field sets both current sources to the same value.
  // RULE9 - Magnitude codes 1 to 9 give 10 to 2000 microamperes; zero and codes 10 to 15 are off.
  // RULE10 - Bits 7:4 of routing connect source two to inputs 0 to 11, the common input, or nothing.
  // RULE11 - Bits 3:0 of routing connect source one the same way and reset to the disconnected code.
  // RULE12 - On the six-input part, codes 6 and 7 reach reference pair one, and inputs 8 to 11 do not exist.
  // RULE13 - Every register keeps all written bits, reserved ones too, and reads them back.
*/
`timescale 1ns/1ps
module vsource_excitation_regs #(
  parameter bit SIX_INPUT_VARIANT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vsource_excitation_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [vsource_excitation_pkg::DATA_W-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [vsource_excitation_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [vsource_excitation_pkg::DATA_W-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic power_down_mode,
  output logic ext_vsource_monitor_en,
  output logic pos_vsource_buffer_bypass,
  output logic neg_vsource_buffer_bypass,
  output logic [1:0] vsource_input_select,
  output logic [1:0] internal_vsource_config,
  output logic vsource_pair0_sel,
  output logic vsource_pair1_sel,
  output logic internal_vsource_sel,
  output logic internal_vsource_on,
  output logic [3:0] excitation_magnitude,
  output logic [11:0] excitation_current_ua,
  output logic current_source_one_en,
  output logic current_source_two_en,
  output logic [3:0] source_one_route,
  output logic [3:0] source_two_route,
  output logic [11:0] source_one_ain_switch,
  output logic source_one_common_switch,
  output logic source_one_pair1_pos_switch,
  output logic source_one_pair1_neg_switch,
  output logic [11:0] source_two_ain_switch,
  output logic source_two_common_switch,
  output logic source_two_pair1_pos_switch,
  output logic source_two_pair1_neg_switch
);
  import vsource_excitation_pkg::*;

  logic wr_en, wr_hit, rd_en, rd_hit;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  logic [REG_W-1:0] vsource_select_control_q;
  logic [REG_W-1:0] excitation_level_q;
  logic [REG_W-1:0] excitation_routing_q;
  logic [REG_W-1:0] status_d;

  input_sel_t sel_field;
  int_config_t config_field;
  logic [3:0] magnitude_field;
  logic [11:0] current_ua_d;
  logic one_connected, two_connected;
  logic ref_on_d, exc_active_d;

  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // Only the three writable words accept writes; the status word answers an error.
  assign wr_hit = (wr_addr == VSOURCE_CTRL_ADDR) || (wr_addr == EXC_LEVEL_ADDR) ||
                  (wr_addr == EXC_ROUTE_ADDR);
  assign rd_hit = wr_hit_for_read(rd_addr);

  function automatic logic wr_hit_for_read(input logic [ADDR_W-1:0] addr);
    return (addr == VSOURCE_CTRL_ADDR) || (addr == EXC_LEVEL_ADDR) ||
           (addr == EXC_ROUTE_ADDR) || (addr == STATUS_ADDR);
  endfunction : wr_hit_for_read

  // The registers are eight bits wide, so only the lowest byte lane carries them.
  // A write whose low strobe is clear is acknowledged but changes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vsource_select_control_q <= VSOURCE_CTRL_RESET; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
    end else if (wr_en && wr_strb[0] && wr_addr == VSOURCE_CTRL_ADDR) begin
      vsource_select_control_q <= wr_data[REG_W-1:0]; // [RULE13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      excitation_level_q <= EXC_LEVEL_RESET; // [RULE9]
    end else if (wr_en && wr_strb[0] && wr_addr == EXC_LEVEL_ADDR) begin
      excitation_level_q <= wr_data[REG_W-1:0]; // [RULE13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      excitation_routing_q <= EXC_ROUTE_RESET; // [RULE10] [RULE11]
    end else if (wr_en && wr_strb[0] && wr_addr == EXC_ROUTE_ADDR) begin
      excitation_routing_q <= wr_data[REG_W-1:0]; // [RULE13]
    end
  end

  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      VSOURCE_CTRL_ADDR: rd_data[REG_W-1:0] = vsource_select_control_q; // [RULE13]
      EXC_LEVEL_ADDR: rd_data[REG_W-1:0] = excitation_level_q; // [RULE13]
      EXC_ROUTE_ADDR: rd_data[REG_W-1:0] = excitation_routing_q; // [RULE13]
      STATUS_ADDR: rd_data[REG_W-1:0] = status_d;
      default: rd_data = '0;
    endcase
  end

  assign sel_field = input_sel_t'(vsource_select_control_q[INPUT_SEL_LSB +: 2]);
  assign config_field = int_config_t'(vsource_select_control_q[INT_CONFIG_LSB +: 2]);
  assign magnitude_field = excitation_level_q[MAGNITUDE_LSB +: 4];

  // The reserved configuration code is treated as off so that an illegal value
  // never powers the internal reference unexpectedly.
  always_comb begin
    ref_on_d = 1'b0;
    unique case (config_field)
      INT_OFF: ref_on_d = 1'b0; // [RULE5]
      INT_ON_SLEEPS: ref_on_d = !power_down_mode; // [RULE5]
      INT_ALWAYS_ON: ref_on_d = 1'b1; // [RULE5]
      INT_RESERVED: ref_on_d = 1'b0; // [RULE5]
    endcase
  end

  assign current_ua_d = magnitude_to_ua(magnitude_field); // [RULE9]
  assign exc_active_d = current_ua_d != 12'h000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_vsource_monitor_en <= 1'b0;
      pos_vsource_buffer_bypass <= 1'b0;
      neg_vsource_buffer_bypass <= 1'b1;
    end else begin
      ext_vsource_monitor_en <= vsource_select_control_q[MONITOR_EN_BIT]; // [RULE1]
      pos_vsource_buffer_bypass <= vsource_select_control_q[POS_BYPASS_BIT]; // [RULE2]
      neg_vsource_buffer_bypass <= vsource_select_control_q[NEG_BYPASS_BIT]; // [RULE3]
    end
  end

  // The reserved selection code leaves every reference path open.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vsource_input_select <= 2'h0;
      vsource_pair0_sel <= 1'b1;
      vsource_pair1_sel <= 1'b0;
      internal_vsource_sel <= 1'b0;
    end else begin
      vsource_input_select <= sel_field;
      vsource_pair0_sel <= sel_field == SEL_PAIR0; // [RULE4]
      vsource_pair1_sel <= sel_field == SEL_PAIR1; // [RULE4]
      internal_vsource_sel <= sel_field == SEL_INTERNAL; // [RULE4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_vsource_config <= 2'h0;
      internal_vsource_on <= 1'b0;
    end else begin
      internal_vsource_config <= config_field;
      internal_vsource_on <= ref_on_d; // [RULE5]
    end
  end

  // Both sources share one magnitude, which keeps them matched for ratiometric use.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      excitation_magnitude <= 4'h0;
      excitation_current_ua <= 12'h000;
    end else begin
      excitation_magnitude <= magnitude_field; // [RULE8]
      excitation_current_ua <= current_ua_d; // [RULE8] [RULE9]
    end
  end

  // Sources are enabled from the registered switch state, so an enable never
  // rises before its route switch has closed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_source_one_en <= 1'b0;
      current_source_two_en <= 1'b0;
    end else begin
      current_source_one_en <= exc_active_d && one_connected; // [RULE8]
      current_source_two_en <= exc_active_d && two_connected; // [RULE8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_one_route <= 4'hF;
      source_two_route <= 4'hF;
    end else begin
      source_one_route <= excitation_routing_q[ROUTE_ONE_LSB +: 4]; // [RULE11]
      source_two_route <= excitation_routing_q[ROUTE_TWO_LSB +: 4]; // [RULE10]
    end
  end

  excitation_route_decoder #(
    .SIX_INPUT_VARIANT(SIX_INPUT_VARIANT)
  ) u_route_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .route_code(excitation_routing_q[ROUTE_ONE_LSB +: 4]),
    .ain_switch(source_one_ain_switch),
    .common_switch(source_one_common_switch),
    .pair1_pos_switch(source_one_pair1_pos_switch),
    .pair1_neg_switch(source_one_pair1_neg_switch),
    .connected(one_connected)
  );

  excitation_route_decoder #(
    .SIX_INPUT_VARIANT(SIX_INPUT_VARIANT)
  ) u_route_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .route_code(excitation_routing_q[ROUTE_TWO_LSB +: 4]),
    .ain_switch(source_two_ain_switch),
    .common_switch(source_two_common_switch),
    .pair1_pos_switch(source_two_pair1_pos_switch),
    .pair1_neg_switch(source_two_pair1_neg_switch),
    .connected(two_connected)
  );

  // Live status: software sequencing slips are reported, not corrected, since
  // the hardware must still follow whatever was written.
  always_comb begin
    status_d = 8'h00;
    status_d[0] = internal_vsource_on;
    status_d[1] = current_source_one_en;
    status_d[2] = current_source_two_en;
    status_d[3] = exc_active_d && !ref_on_d; // [RULE7]
    status_d[4] = (sel_field == SEL_INTERNAL) && !(vsource_select_control_q[POS_BYPASS_BIT] &&
                  vsource_select_control_q[NEG_BYPASS_BIT]); // [RULE6]
    status_d[5] = (sel_field == SEL_RESERVED) || (config_field == INT_RESERVED);
    status_d[6] = one_connected && two_connected &&
                  (excitation_routing_q[ROUTE_ONE_LSB +: 4] == excitation_routing_q[ROUTE_TWO_LSB +: 4]);
  end

endmodule : vsource_excitation_regs

// *** vsource_excitation_regs_props.sv ***
/* Checker for the reference and excitation register slice.
   Assumes the twelve-input variant and a bind onto the top module. */
`timescale 1ns/1ps
module vsource_excitation_regs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic power_down_mode,
  input wire logic [1:0] vsource_input_select,
  input wire logic [1:0] internal_vsource_config,
  input wire logic vsource_pair0_sel,
  input wire logic vsource_pair1_sel,
  input wire logic internal_vsource_sel,
  input wire logic internal_vsource_on,
  input wire logic [3:0] excitation_magnitude,
  input wire logic [11:0] excitation_current_ua,
  input wire logic current_source_one_en,
  input wire logic [3:0] source_one_route,
  input wire logic [3:0] source_two_route,
  input wire logic [11:0] source_one_ain_switch,
  input wire logic source_two_common_switch
);
  logic mag_on;
  logic one_q;
  assign mag_on = excitation_magnitude != 4'h0 && excitation_magnitude <= 4'h9;
  // The route half of the enable trails the field outputs by one stage; the magnitude half does not.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      one_q <= 1'b0;
    end else begin
      one_q <= (source_one_route <= 4'hC);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken_s;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence wr_answer_s;
    s_axil_bvalid && !s_axil_awready && !s_axil_wready;
  endsequence
  sel_onehot_a: assert property (
    {vsource_pair0_sel, vsource_pair1_sel, internal_vsource_sel} ==
    (vsource_input_select == 2'h3 ? 3'h0 : 3'h4 >> vsource_input_select)) else $error("select one-hot wrong");
  int_on_a: assert property (
    internal_vsource_on == (internal_vsource_config == 2'h2 ||
    (internal_vsource_config == 2'h1 && !$past(power_down_mode)))) else $error("internal reference state wrong");
  ua_off_a: assert property (!mag_on |-> excitation_current_ua == 12'h000) else $error("current not off");
  en_one_a: assert property (current_source_one_en == (mag_on && one_q))
    else $error("source one enable wrong");
  ain_sw_a: assert property (
    source_one_ain_switch == (source_one_route <= 4'hB ? 12'h001 << source_one_route : 12'h000))
    else $error("source one switch wrong");
  common_sw_a: assert property (
    source_two_common_switch == (source_two_route == 4'hC)) else $error("source two common switch wrong");
  wr_answer_a: assert property (wr_taken_s |=> wr_answer_s) else $error("write answer late");
  rd_answer_a: assert property (
    s_axil_arvalid && s_axil_arready |=> s_axil_rvalid && !s_axil_arready) else $error("read answer late");
endmodule : vsource_excitation_regs_props

bind vsource_excitation_regs vsource_excitation_regs_props i_props (.*);

// *** vsource_excitation_regs_test.sv ***
/* Self-checking bench for the reference and excitation register slice.
   Assumes the package, design and checker files are compiled first. */
`timescale 1ns/1ps
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module vsource_excitation_regs_test;
  import vsource_excitation_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b1;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b1, power_down_mode = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hF, excitation_magnitude, source_one_route, source_two_route;
  logic [1:0] s_axil_bresp, s_axil_rresp, vsource_input_select, internal_vsource_config;
  logic [11:0] excitation_current_ua, source_one_ain_switch, source_two_ain_switch;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, ext_vsource_monitor_en;
  logic pos_vsource_buffer_bypass, neg_vsource_buffer_bypass, vsource_pair0_sel, vsource_pair1_sel;
  logic internal_vsource_sel, internal_vsource_on, current_source_one_en, current_source_two_en;
  logic source_one_common_switch, source_two_common_switch, source_one_pair1_pos_switch;
  logic source_one_pair1_neg_switch, source_two_pair1_pos_switch, source_two_pair1_neg_switch;
  int error_cnt = 0, checked = 0;
  always #12.5 aclk = ~aclk;
  vsource_excitation_regs i_vsource_excitation_regs (.*);
  task automatic finish_test;
    $display("Counts: %0d checked, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h000000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid) begin
        r = s_axil_bresp;
        return;
      end
    end
    error_cnt++;
    finish_test();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid) begin
        d = s_axil_rdata;
        r = s_axil_rresp;
        return;
      end
    end
    error_cnt++;
    finish_test();
  endtask : rd
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    logic [31:0] q;
    wr(a, d, r);
    `CK("bresp", RESP_OKAY, r)
    rd(a, q, r);
    `CK("readback", {24'h000000, d}, q)
    repeat (3) @(posedge aclk);
  endtask : put
  task automatic t_reset;
    logic [1:0] r;
    logic [31:0] q;
    rd(VSOURCE_CTRL_ADDR, q, r);
    `CK("ctrl reset", 32'h10, q)
    rd(EXC_LEVEL_ADDR, q, r);
    `CK("level reset", 32'h00, q)
    rd(EXC_ROUTE_ADDR, q, r);
    `CK("route reset", 32'hFF, q)
    `CK("monitor", 1'b0, ext_vsource_monitor_en)
    `CK("neg bypass", 1'b1, neg_vsource_buffer_bypass)
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl;
    for (int i = 0; i < 256; i++) begin
      put(VSOURCE_CTRL_ADDR, 8'(i));
      `CK("monitor", i[6], ext_vsource_monitor_en)
      `CK("pos bypass", i[5], pos_vsource_buffer_bypass)
      `CK("neg bypass", i[4], neg_vsource_buffer_bypass)
      `CK("select", 2'(i >> 2), vsource_input_select)
      `CK("int on", i[1] ^ i[0], internal_vsource_on)
      `CK("config", 2'(i), internal_vsource_config)
    end
    power_down_mode <= 1'b1;
    put(VSOURCE_CTRL_ADDR, 8'h01);
    `CK("sleeps", 1'b0, internal_vsource_on)
    put(VSOURCE_CTRL_ADDR, 8'h02);
    `CK("stays on", 1'b1, internal_vsource_on)
    power_down_mode <= 1'b0;
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_level;
    logic [11:0] ua [16] = '{1: 12'h00A, 2: 12'h032, 3: 12'h064, 4: 12'h0FA, 5: 12'h1F4, 6: 12'h2EE,
      7: 12'h3E8, 8: 12'h5DC, 9: 12'h7D0, default: 12'h000};
    put(VSOURCE_CTRL_ADDR, 8'h3A);
    put(EXC_ROUTE_ADDR, 8'hC0);
    for (int c = 0; c < 16; c++) begin
      put(EXC_LEVEL_ADDR, {4'(15 - c), 4'(c)});
      `CK("microamps", ua[c], excitation_current_ua)
      `CK("one en", ua[c] != 12'h000, current_source_one_en)
      `CK("two en", ua[c] != 12'h000, current_source_two_en)
    end
    $display("test level done");
  endtask : t_level
  task automatic t_route;
    logic [1:0] r;
    logic [31:0] q;
    put(EXC_LEVEL_ADDR, 8'h01);
    for (int c = 0; c < 16; c++) begin
      put(EXC_ROUTE_ADDR, {4'(c), 4'(15 - c)});
      `CK("two ain", c <= 11 ? 12'h001 << c : 12'h000, source_two_ain_switch)
      `CK("two common", c == 12, source_two_common_switch)
      `CK("two en", c <= 12, current_source_two_en)
      `CK("two route", 4'(c), source_two_route)
      `CK("one ain", c >= 4 ? 12'h001 << (15 - c) : 12'h000, source_one_ain_switch)
      `CK("one common", c == 3, source_one_common_switch)
      `CK("one en", c >= 3, current_source_one_en)
    end
    wr(STATUS_ADDR, 8'h00, r);
    `CK("status bresp", RESP_SLVERR, r)
    rd(STATUS_ADDR, q, r);
    `CK("status", 32'h03, q)
    $display("test route done");
  endtask : t_route
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ctrl();
    t_level();
    t_route();
    finish_test();
  end
endmodule : vsource_excitation_regs_test
